//--- pkg/swid_defines.svh
// Timing, identity layout and command codes for the single-wire identity link.
// Assumes a 40 MHz system clock on both ends.
//
// Overview of operation
// - Identity: family byte, 48-bit serial, check byte
// - Check value uses x^8+x^5+x^4+1 feedback
// - Check starts zero, fed LSB first, family first
// - Feeding stored check byte leaves zero remainder
// - Device is slave; only presence is self-started
// - Both ends drive line open-drain, wired-AND
// - Standard speed stays at or below 16.3kbps
// - Master idles and pauses with line released
// - Line low over 120us resets the device
// - Every transaction: initialization, then ROM command
// - Master reset pulse, then slave presence pulse
// - Presence only after a reset pulse
// - Master waits reset high time before next
// - Master keeps reset pulse at most 960us
// - Master falling edge starts and times each slot
// - Command 33h sends whole identity in slots
// - Command F0h: bit, complement, compare, maybe drop
// - Presence: wait 15-60us, then low 60-240us
// - Read zero pulls low, then timed release
`ifndef SWID_DEFINES_SVH
`define SWID_DEFINES_SVH

`define SWID_CLK_MHZ 40

`define SWID_ID_BITS 64
`define SWID_FAMILY_LSB 0
`define SWID_SERIAL_LSB 8
`define SWID_CHECK_LSB 56
`define SWID_CRC_INIT 8'h00
`define SWID_CRC_POLY 8'h8c

`define SWID_CMD_READ_ID 8'h33
`define SWID_CMD_SEARCH 8'hf0

// Device side times in microseconds, then cycles
`define SWID_RESET_DETECT_US 120
`define SWID_RESET_DETECT_CYC (`SWID_RESET_DETECT_US * `SWID_CLK_MHZ)
`define SWID_PRESENCE_WAIT_US 30
`define SWID_PRESENCE_WAIT_CYC (`SWID_PRESENCE_WAIT_US * `SWID_CLK_MHZ)
`define SWID_PRESENCE_LOW_US 100
`define SWID_PRESENCE_LOW_CYC (`SWID_PRESENCE_LOW_US * `SWID_CLK_MHZ)
`define SWID_DEV_SLOT_US 30
`define SWID_DEV_SLOT_CYC (`SWID_DEV_SLOT_US * `SWID_CLK_MHZ)

// Master side times in microseconds, then cycles
`define SWID_RESET_LOW_US 480
`define SWID_RESET_LOW_CYC (`SWID_RESET_LOW_US * `SWID_CLK_MHZ)
`define SWID_RESET_HIGH_US 480
`define SWID_RESET_HIGH_CYC (`SWID_RESET_HIGH_US * `SWID_CLK_MHZ)
`define SWID_PRESENCE_SAMPLE_US 70
`define SWID_PRESENCE_SAMPLE_CYC (`SWID_PRESENCE_SAMPLE_US * `SWID_CLK_MHZ)
`define SWID_WRITE_ZERO_LOW_US 80
`define SWID_WRITE_ZERO_LOW_CYC (`SWID_WRITE_ZERO_LOW_US * `SWID_CLK_MHZ)
`define SWID_READ_LOW_US 5
`define SWID_READ_LOW_CYC (`SWID_READ_LOW_US * `SWID_CLK_MHZ)
`define SWID_READ_SAMPLE_US 13
`define SWID_READ_SAMPLE_CYC (`SWID_READ_SAMPLE_US * `SWID_CLK_MHZ)
`define SWID_SLOT_US 75
`define SWID_SLOT_CYC (`SWID_SLOT_US * `SWID_CLK_MHZ)

`endif

//--- pkg/swid_pkg.sv
// Types and check-value arithmetic shared by both ends of the link.
// Assumes the defines header is included by the user modules.
package swid_pkg;

  typedef logic [15:0] swid_cnt_t;

  typedef enum logic [1:0] {
    SWID_OP_RESET,
    SWID_OP_WRITE,
    SWID_OP_READ
  } swid_op_e;

  // One step of the reflected shift-register check generator
  function automatic logic [7:0] swid_crc_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[0] ^ bit_in;
    swid_crc_step = {1'b0, crc[7:1]} ^ (fb ? 8'h8c : 8'h00);
  endfunction

  // Check value over the first 56 identity bits
  function automatic logic [7:0] swid_crc56(input logic [55:0] data);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
    begin
      c = swid_crc_step(c, data[i]);
    end
    swid_crc56 = c;
  endfunction

endpackage

//--- pkg/swid_if.sv
// Shared open-drain line between one master and one identity slave.
// Assumes an external pull-up: the line is high unless someone drives it.
`timescale 1ns/100ps
interface swid_if;
  logic m_o;
  logic m_oe_n;
  logic s_o;
  logic s_oe_n;
  wire line;

  // Wired-AND of both open-drain drivers
  assign line = (m_oe_n | m_o) & (s_oe_n | s_o);

  modport slave (input line, output s_o, output s_oe_n);
  modport master (input line, output m_o, output m_oe_n);
endinterface

//--- design/swid_slave.sv
// Identity slave end of the single-wire link.
// Assumes one master on the line and a 40 MHz clock for all timing.
`timescale 1ns/100ps
`include "swid_defines.svh"

module swid_slave
  import swid_pkg::*;
#(
  // Arbitrary identity values
  parameter logic [7:0] FAMILY = 8'h5a,
  parameter logic [47:0] SERIAL = 48'h0123_4567_89ab,
  parameter int RESET_DETECT_CYC = `SWID_RESET_DETECT_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Line
  swid_if.slave bus,
  // User side status
  output logic active,
  output logic presence_sent
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET,
    ST_PRES_WAIT,
    ST_PRES_LOW,
    ST_CMD,
    ST_READ,
    ST_SEARCH,
    ST_SILENT
  } swid_st_e;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    swid_st_e st;
    swid_cnt_t lowcnt;
    swid_cnt_t tcnt;
    logic inslot;
    logic [6:0] bitcnt;
    logic [1:0] phase;
    logic [7:0] cmd;
    logic drive_n;
    logic out;
    logic active;
    logic pres;
  } swid_slv_s;

  localparam logic [55:0] ID56 = {SERIAL, FAMILY};
  localparam logic [63:0] ID = {swid_crc56(ID56), ID56};

  swid_slv_s q;
  swid_slv_s d;

  // Bit the device would put on the line in the current slot
  function automatic logic tx_bit(input swid_slv_s s);
    logic b;
    b = ID[s.bitcnt[5:0]];
    if (s.st == ST_SEARCH && s.phase == 2'd1)
    begin
      b = ~b;
    end
    tx_bit = b;
  endfunction

  function automatic logic is_tx(input swid_slv_s s);
    is_tx = (s.st == ST_READ) || (s.st == ST_SEARCH && s.phase != 2'd2);
  endfunction

  always_comb
  begin
    logic fall;
    fall = 1'b0;
    d = q;
    // Two flip-flops before anything looks at the line
    d.sync1 = bus.line;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    fall = q.prev & ~q.sync2;
    d.out = 1'b0;

    // Our read-zero may overlap the start of a reset pulse, so it counts too
    // Own presence low counts only for two cycles, while the synchronizer lags its release
    if (!q.sync2 && q.st != ST_PRES_LOW)
    begin
      if (q.lowcnt != 16'hffff)
      begin
        d.lowcnt = q.lowcnt + 16'd1;
      end
    end
    else
    begin
      d.lowcnt = '0;
    end

    case (q.st)
      ST_IDLE, ST_SILENT:
      begin
        d.drive_n = 1'b1;
      end
      ST_RESET:
      begin
        if (q.sync2)
        begin
          d.st = ST_PRES_WAIT;
          d.tcnt = '0;
        end
      end
      ST_PRES_WAIT:
      begin
        d.tcnt = q.tcnt + 16'd1;
        if (q.tcnt == swid_cnt_t'(`SWID_PRESENCE_WAIT_CYC - 1))
        begin
          d.st = ST_PRES_LOW;
          d.drive_n = 1'b0;
          d.tcnt = '0;
          d.pres = 1'b1;
        end
      end
      ST_PRES_LOW:
      begin
        d.tcnt = q.tcnt + 16'd1;
        if (q.tcnt == swid_cnt_t'(`SWID_PRESENCE_LOW_CYC - 1))
        begin
          d.st = ST_CMD;
          d.drive_n = 1'b1;
          d.bitcnt = '0;
          d.inslot = 1'b0;
          d.active = 1'b1;
        end
      end
      ST_CMD, ST_READ, ST_SEARCH:
      begin
        if (!q.inslot)
        begin
          if (fall)
          begin
            d.inslot = 1'b1;
            d.tcnt = '0;
            if (is_tx(q) && !tx_bit(q))
            begin
              d.drive_n = 1'b0;
            end
          end
        end
        else
        begin
          d.tcnt = q.tcnt + 16'd1;
          if (q.tcnt == swid_cnt_t'(`SWID_DEV_SLOT_CYC - 1))
          begin
            // Release and sample share one instant; master write-zero outlasts it
            d.inslot = 1'b0;
            d.drive_n = 1'b1;
            case (q.st)
              ST_CMD:
              begin
                d.cmd = {q.sync2, q.cmd[7:1]};
                d.bitcnt = q.bitcnt + 7'd1;
                if (q.bitcnt == 7'd7)
                begin
                  d.bitcnt = '0;
                  d.phase = '0;
                  if (d.cmd == `SWID_CMD_READ_ID)
                  begin
                    d.st = ST_READ;
                  end
                  else if (d.cmd == `SWID_CMD_SEARCH)
                  begin
                    d.st = ST_SEARCH;
                  end
                  else
                  begin
                    d.st = ST_SILENT;
                    d.active = 1'b0;
                  end
                end
              end
              ST_READ:
              begin
                d.bitcnt = q.bitcnt + 7'd1;
                if (q.bitcnt == 7'(`SWID_ID_BITS - 1))
                begin
                  d.st = ST_SILENT;
                  d.active = 1'b0;
                end
              end
              ST_SEARCH:
              begin
                if (q.phase != 2'd2)
                begin
                  d.phase = q.phase + 2'd1;
                end
                else
                begin
                  d.phase = '0;
                  d.bitcnt = q.bitcnt + 7'd1;
                  if (q.sync2 != ID[q.bitcnt[5:0]])
                  begin
                    d.st = ST_SILENT;
                    d.active = 1'b0;
                  end
                  else if (q.bitcnt == 7'(`SWID_ID_BITS - 1))
                  begin
                    d.st = ST_SILENT;
                    d.active = 1'b0;
                  end
                end
              end
              default:
              begin
                d.st = ST_SILENT;
              end
            endcase
          end
        end
      end
      default:
      begin
        d.st = ST_IDLE;
        d.drive_n = 1'b1;
      end
    endcase

    // Long low wins over everything and abandons the transaction
    if (!q.sync2 && q.st != ST_PRES_LOW && q.lowcnt >= swid_cnt_t'(RESET_DETECT_CYC - 1))
    begin
      d.st = ST_RESET;
      d.drive_n = 1'b1;
      d.inslot = 1'b0;
      d.active = 1'b0;
      d.pres = 1'b0;
    end
    if (q.st != ST_PRES_WAIT || d.st != ST_PRES_LOW)
    begin
      d.pres = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      q <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.prev <= 1'b1;
      q.st <= ST_IDLE;
      q.drive_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Open drain: data stays low, only the enable moves
  assign bus.s_o = q.out;
  assign bus.s_oe_n = q.drive_n;
  assign active = q.active;
  assign presence_sent = q.pres;

endmodule // swid_slave

//--- design/swid_master.sv
// Master end of the single-wire link: reset, write-bit and read-bit slots.
// Assumes a user that issues one operation at a time while busy is low.
`timescale 1ns/100ps
`include "swid_defines.svh"

module swid_master
  import swid_pkg::*;
#(
  parameter int RESET_LOW_CYC = `SWID_RESET_LOW_CYC,
  parameter int RESET_HIGH_CYC = `SWID_RESET_HIGH_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Line
  swid_if.master bus,
  // Operation request
  input wire logic op_valid,
  input wire swid_op_e op,
  input wire logic op_bit,
  // Results
  output logic busy,
  output logic done,
  output logic rd_bit,
  output logic presence,
  output logic crc_ok
);

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_RST_LOW,
    MS_RST_HIGH,
    MS_SLOT
  } swid_mst_e;

  typedef struct packed {
    logic sync1;
    logic sync2;
    swid_mst_e st;
    swid_cnt_t tcnt;
    swid_op_e op;
    logic wbit;
    logic drive_n;
    logic out;
    logic busy;
    logic done;
    logic rd_bit;
    logic presence;
    logic [7:0] crc;
    logic crc_ok;
  } swid_mst_s;

  swid_mst_s q;
  swid_mst_s d;

  always_comb
  begin
    d = q;
    d.sync1 = bus.line;
    d.sync2 = q.sync1;
    d.done = 1'b0;
    d.out = 1'b0;
    d.crc_ok = (q.crc == `SWID_CRC_INIT);
    case (q.st)
      MS_IDLE:
      begin
        // Line left released between operations
        d.drive_n = 1'b1;
        if (op_valid)
        begin
          d.busy = 1'b1;
          d.op = op;
          d.wbit = op_bit;
          d.tcnt = '0;
          d.drive_n = 1'b0;
          if (op == SWID_OP_RESET)
          begin
            d.st = MS_RST_LOW;
            d.crc = `SWID_CRC_INIT;
          end
          else
          begin
            d.st = MS_SLOT;
          end
        end
      end
      MS_RST_LOW:
      begin
        d.tcnt = q.tcnt + 16'd1;
        if (q.tcnt == swid_cnt_t'(RESET_LOW_CYC - 1))
        begin
          d.drive_n = 1'b1;
          d.tcnt = '0;
          d.presence = 1'b0;
          d.st = MS_RST_HIGH;
        end
      end
      MS_RST_HIGH:
      begin
        d.tcnt = q.tcnt + 16'd1;
        if (q.tcnt == swid_cnt_t'(`SWID_PRESENCE_SAMPLE_CYC - 1))
        begin
          d.presence = ~q.sync2;
        end
        if (q.tcnt == swid_cnt_t'(RESET_HIGH_CYC - 1))
        begin
          d.st = MS_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
      MS_SLOT:
      begin
        d.tcnt = q.tcnt + 16'd1;
        if (q.op == SWID_OP_WRITE && q.wbit == 1'b0)
        begin
          if (q.tcnt == swid_cnt_t'(`SWID_WRITE_ZERO_LOW_CYC - 1))
          begin
            d.drive_n = 1'b1;
          end
        end
        else if (q.tcnt == swid_cnt_t'(`SWID_READ_LOW_CYC - 1))
        begin
          d.drive_n = 1'b1;
        end
        if (q.op == SWID_OP_READ && q.tcnt == swid_cnt_t'(`SWID_READ_SAMPLE_CYC - 1))
        begin
          d.rd_bit = q.sync2;
          d.crc = swid_crc_step(q.crc, q.sync2);
        end
        // Slot length keeps the bit rate under the standard-speed limit
        if (q.tcnt == swid_cnt_t'(`SWID_SLOT_CYC - 1))
        begin
          d.st = MS_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
      default:
      begin
        d.st = MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      q <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.st <= MS_IDLE;
      q.op <= SWID_OP_RESET;
      q.drive_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus.m_o = q.out;
  assign bus.m_oe_n = q.drive_n;
  assign busy = q.busy;
  assign done = q.done;
  assign rd_bit = q.rd_bit;
  assign presence = q.presence;
  assign crc_ok = q.crc_ok;

endmodule // swid_master

//--- testbench/swid_chk.sv
// Checker on the shared line between master and identity slave.
// Assumes the interface wires, the common clock and reset as inputs.
`timescale 1ns/100ps
module swid_chk
#(
  parameter int RESET_DETECT_CYC = 4800,
  parameter int RESET_LOW_CYC = 5000,
  parameter int RESET_HIGH_CYC = 6000
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Line
  input wire logic m_o,
  input wire logic m_oe_n,
  input wire logic s_o,
  input wire logic s_oe_n,
  input wire logic line
);
  logic [15:0] s_lo, m_lo, m_hi, m_gap, hi, lo, lo_len;
  logic m_rst;

  // Run-length counters; gap saturates so idle time cannot wrap it
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_lo <= 16'h0;
      m_lo <= 16'h0;
      m_hi <= 16'h0;
      m_gap <= 16'hffff;
      hi <= 16'h0;
      lo <= 16'h0;
      lo_len <= 16'h0;
      m_rst <= 1'b0;
    end
    else
    begin
      s_lo <= s_oe_n ? 16'h0 : s_lo + 16'h1;
      m_lo <= m_oe_n ? 16'h0 : m_lo + 16'h1;
      m_hi <= m_oe_n ? m_hi + 16'h1 : 16'h0;
      m_gap <= $fell(m_oe_n) ? 16'h1 : ((m_gap == 16'hffff) ? m_gap : m_gap + 16'h1);
      hi <= line ? hi + 16'h1 : 16'h0;
      lo <= line ? 16'h0 : lo + 16'h1;
      lo_len <= line ? lo_len : lo + 16'h1;
      m_rst <= $rose(m_oe_n) ? (m_lo >= RESET_LOW_CYC) : ($fell(m_oe_n) ? 1'b0 : m_rst);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_master_od; !m_oe_n |-> !m_o; endproperty
  a_master_od: assert property (p_master_od) else $error("master drives high");
  property p_slave_od; !s_oe_n |-> !s_o; endproperty
  a_slave_od: assert property (p_slave_od) else $error("slave drives high");
  property p_slave_low_len;
    $rose(s_oe_n) |-> (s_lo inside {[1100:1300]}) || (s_lo inside {[2400:9600]});
  endproperty
  a_slave_low_len: assert property (p_slave_low_len) else $error("slave low length");
  property p_presence_wait; $fell(s_oe_n) && $past(line) |-> hi inside {[600:2400]}; endproperty
  a_presence_wait: assert property (p_presence_wait) else $error("presence wait");
  property p_presence_after_reset;
    $fell(s_oe_n) && $past(line) |-> lo_len >= RESET_DETECT_CYC;
  endproperty
  a_presence_after_reset: assert property (p_presence_after_reset) else $error("no reset");
  property p_read_follows_fall; $fell(s_oe_n) && !$past(line) |-> lo <= 16'd8; endproperty
  a_read_follows_fall: assert property (p_read_follows_fall) else $error("late reply");
  property p_reset_low_max; $rose(m_oe_n) |-> m_lo <= 16'd38400; endproperty
  a_reset_low_max: assert property (p_reset_low_max) else $error("reset too long");
  property p_reset_high; $fell(m_oe_n) && m_rst |-> m_hi >= RESET_HIGH_CYC - 2; endproperty
  a_reset_high: assert property (p_reset_high) else $error("reset high cut");
  property p_bit_rate; $fell(m_oe_n) |-> m_gap >= 16'd2454; endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("slots too close");
endmodule // swid_chk

//--- testbench/tb_single_wire_serial_id_slave.sv
// Bench joining master and slave ends; random and corner traffic.
// Assumes the defines header on the include path and a 40 MHz clock.
`timescale 1ns/100ps
`include "swid_defines.svh"
module tb_single_wire_serial_id_slave;
  import swid_pkg::*;
  localparam logic [7:0] FAM = 8'h6d;
  localparam logic [47:0] SER = 48'h3c5a_0f96_e1b2;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  logic op_bit = 1'b0;
  swid_op_e op = SWID_OP_RESET;
  logic busy, done, rd_bit, presence, crc_ok, active, presence_sent;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int ps_cnt = 0;
  logic [7:0] crc = 8'h0;

  swid_if bus_if();
  swid_slave #(.FAMILY(FAM), .SERIAL(SER)) swid_slave_inst (.clock(clock), .reset(reset),
    .bus(bus_if.slave), .active(active), .presence_sent(presence_sent));
  // Reset low kept near the detect time to save run length
  swid_master #(.RESET_LOW_CYC(5000), .RESET_HIGH_CYC(6000)) swid_master_inst (.clock(clock),
    .reset(reset), .bus(bus_if.master), .op_valid(op_valid), .op(op), .op_bit(op_bit),
    .busy(busy), .done(done), .rd_bit(rd_bit), .presence(presence), .crc_ok(crc_ok));
  swid_chk #(.RESET_LOW_CYC(5000), .RESET_HIGH_CYC(6000)) swid_chk_inst (.clock(clock),
    .reset(reset), .m_o(bus_if.m_o), .m_oe_n(bus_if.m_oe_n), .s_o(bus_if.s_o),
    .s_oe_n(bus_if.s_oe_n), .line(bus_if.line));

  always #12.5 clock = ~clock;

  always @(posedge clock)
  begin
    if (presence_sent === 1'b1)
      ps_cnt++;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 120000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic b);
    crc_upd = (c >> 1) ^ ((c[0] ^ b) ? 8'h8c : 8'h00);
  endfunction

  task automatic chk(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp)
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    if (got !== exp)
      error_cnt++;
  endtask

  task automatic do_op(input swid_op_e o, input logic b);
    int n;
    n = 0;
    @(negedge clock);
    op <= o;
    op_bit <= b;
    op_valid <= 1'b1;
    @(negedge clock);
    op_valid <= 1'b0;
    chk("busy", 1'b1, busy);
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic rd(output logic b);
    do_op(SWID_OP_READ, 1'b1);
    b = rd_bit;
    crc = crc_upd(crc, b);
  endtask

  task automatic wr_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      do_op(SWID_OP_WRITE, v[i]);
  endtask

  task automatic rst_seq();
    do_op(SWID_OP_RESET, 1'b0);
    crc = 8'h0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    logic b, t, c, w;
    int k;
    void'($urandom(75));
    repeat (12) @(negedge clock);
    reset <= 1'b0;
    rd(b);
    chk("silent_bit", 1'b1, b);
    chk("no_presence", 1'b1, ps_cnt == 0);
    chk("inactive", 1'b0, active);
    $display("test silent_before_reset done");
    rst_seq();
    chk("presence", 1'b1, presence);
    chk("presence_pulses", 1'b1, ps_cnt == 1);
    chk("crc_ok_clear", 1'b1, crc_ok);
    wr_byte(`SWID_CMD_READ_ID);
    k = 4 + ($urandom % 3);
    for (int i = 0; i < k; i++)
    begin
      rd(b);
      chk("family_bit", FAM[i], b);
    end
    chk("crc_ok", crc == 8'h0, crc_ok);
    chk("active_read", 1'b1, active);
    $display("test read_identity done");
    rst_seq();
    chk("presence_again", 1'b1, ps_cnt == 2);
    wr_byte(`SWID_CMD_SEARCH);
    rd(t);
    rd(c);
    chk("search_true", FAM[0], t);
    chk("search_comp", ~FAM[0], c);
    w = 1'($urandom & 1);
    do_op(SWID_OP_WRITE, w);
    rd(t);
    rd(c);
    chk("next_true", (w == FAM[0]) ? FAM[1] : 1'b1, t);
    chk("next_comp", (w == FAM[0]) ? ~FAM[1] : 1'b1, c);
    chk("search_active", w == FAM[0], active);
    $display("test search done");
    stop_test();
  end
endmodule // tb_single_wire_serial_id_slave
